// ===== verilog/cadc_regs.vh
// Constants for the converter control and serial readout block
`ifndef CADC_REGS_VH
`define CADC_REGS_VH

// Core clock rate
`define CADC_CLK_MHZ 100

// Conversion time limits in ns
`define CADC_TCONV_MIN_NS 300
`define CADC_TCONV_MAX_NS 700

// Conversion time limits in core cycles, min rounds up, max rounds down
`define CADC_TCONV_MIN_CYC ((`CADC_TCONV_MIN_NS * `CADC_CLK_MHZ + 999) / 1000)
`define CADC_TCONV_MAX_CYC ((`CADC_TCONV_MAX_NS * `CADC_CLK_MHZ) / 1000)

// Result width and serial frame lengths
`define CADC_DATA_W 16
`define CADC_FRAME_W 17
`define CADC_EDGES_PLAIN 5'h10
`define CADC_EDGES_BUSY 5'h11

// Busy indicator level
`define CADC_BUSY_LEVEL 1'h0

// Conversion timer width and jitter seed
`define CADC_CNT_W 10
`define CADC_LFSR_SEED 8'hA5

// Pin bit positions in the synchroniser vectors
`define CADC_PIN_TRIG 0
`define CADC_PIN_MODE 1
`define CADC_PIN_SCLK 2

`endif

// ===== verilog/cadc_conv_timer.v
// Conversion timer with a varying duration between two limits
`timescale 1ns/10ps
`include "cadc_regs.vh"

module cadc_conv_timer #(
  parameter CNT_W = `CADC_CNT_W,
  parameter [CNT_W-1:0] MIN_CYCLES = `CADC_TCONV_MIN_CYC,
  parameter [CNT_W-1:0] MAX_CYCLES = `CADC_TCONV_MAX_CYC
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Control
  input wire start,
  // Status
  output wire running,
  output wire done
);

  reg run_reg;
  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] target_reg;
  reg [7:0] lfsr_reg;
  wire [CNT_W-1:0] jitter;
  wire [CNT_W-1:0] sum;
  wire [CNT_W-1:0] target_next;

  // Length varies per sample, clipped into the limits
  assign jitter = {{(CNT_W-4){1'b0}}, lfsr_reg[3:0]};
  assign sum = MIN_CYCLES + jitter;
  assign target_next = (sum > MAX_CYCLES) ? MAX_CYCLES : sum;
  assign running = run_reg;
  assign done = run_reg && (count_reg == target_reg);

  // Free running pseudo random source
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lfsr_reg <= `CADC_LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
  end

  // Internal clock counting of the conversion
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      run_reg <= 1'b0;
      count_reg <= {CNT_W{1'b0}};
      target_reg <= MIN_CYCLES;
    end else if (start && !run_reg) begin
      run_reg <= 1'b1;
      count_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
      target_reg <= target_next;
    end else if (done) begin
      run_reg <= 1'b0;
      count_reg <= {CNT_W{1'b0}};
    end else if (run_reg) begin
      count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ===== verilog/cadc_readout.v
// Conversion control and serial result readout, chip-select interface family
//
// How it works
// - Internal clock times conversion; serial clock reads
// - Conversion length stays within both time limits
// - Result is unsigned straight binary sixteen bits
// - Trigger rise with mode input high: chip-select
// - Mode low or tied to trigger: daisy-chain
// - Optional low busy bit precedes the result
// - Trigger rise floats output, samples, starts converting
// - Running conversion ignores later trigger levels
// - Trigger or mode level at conversion end selects busy bit
// - Trigger fall after conversion drives the MSB
// - Float at sixteenth clock fall or trigger rise
// - Busy mode: end drives busy bit, then MSB first
// - Busy float at seventeenth clock fall or trigger rise
// - Four-wire: mode input fall drives the MSB
// - Four-wire float at mode rise or last fall
// - Bits change at serial clock fall, hold across the rise
`timescale 1ns/10ps
`include "cadc_regs.vh"

module cadc_readout #(
  parameter DATA_W = `CADC_DATA_W,
  parameter FRAME_W = `CADC_FRAME_W,
  parameter CNT_W = `CADC_CNT_W,
  parameter [CNT_W-1:0] MIN_CYCLES = `CADC_TCONV_MIN_CYC,
  parameter [CNT_W-1:0] MAX_CYCLES = `CADC_TCONV_MAX_CYC
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Device pins
  input wire conversion_trigger,
  input wire mode_select,
  input wire serial_clk,
  output wire serial_out,
  output wire serial_out_oe_n,
  // Quantizer side
  input wire [DATA_W-1:0] quantizer_code,
  output wire sample_hold,
  // Status
  output wire chip_select_mode,
  output wire daisy_chain_mode,
  output wire busy_bit_armed,
  output wire converting,
  output wire acquisition_power_down,
  output wire [DATA_W-1:0] last_result
);

  localparam ST_IDLE = 4'h1;
  localparam ST_CONV = 4'h2;
  localparam ST_READY = 4'h4;
  localparam ST_SHIFT = 4'h8;

  // Edge test on synchronised pins
  function edge_seen;
    input prev;
    input now;
    input rising;
    begin
      edge_seen = rising ? (!prev && now) : (prev && !now);
    end
  endfunction

  reg [2:0] meta_reg;
  reg [2:0] sync_reg;
  reg [2:0] prev_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg cs_mode_reg;
  reg cs_mode_next;
  reg busy_reg;
  reg busy_next;
  reg [DATA_W-1:0] result_reg;
  reg [FRAME_W-1:0] shift_reg;
  reg [FRAME_W-1:0] shift_next;
  reg [4:0] edge_cnt_reg;
  reg [4:0] edge_cnt_next;
  reg oe_n_reg;
  reg oe_n_next;
  reg out_reg;
  reg sample_reg;
  reg start_conv;
  wire trig_s;
  wire mode_s;
  wire trig_rise;
  wire mode_rise;
  wire sel_fall;
  wire sclk_fall;
  wire conv_done;
  wire conv_running;
  wire [4:0] edge_limit;

  // Two stage synchronisers for all pins
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prev_reg <= 3'h0;
    end else begin
      meta_reg <= {serial_clk, mode_select, conversion_trigger};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign trig_s = sync_reg[`CADC_PIN_TRIG];
  assign mode_s = sync_reg[`CADC_PIN_MODE];
  assign trig_rise = edge_seen(prev_reg[`CADC_PIN_TRIG], trig_s, 1'b1);
  assign mode_rise = edge_seen(prev_reg[`CADC_PIN_MODE], mode_s, 1'b1);
  // Select is active while either trigger or mode input is low
  assign sel_fall = edge_seen(prev_reg[`CADC_PIN_TRIG] & prev_reg[`CADC_PIN_MODE],
                              trig_s & mode_s, 1'b0);
  assign sclk_fall = edge_seen(prev_reg[`CADC_PIN_SCLK], sync_reg[`CADC_PIN_SCLK], 1'b0);
  assign edge_limit = busy_reg ? `CADC_EDGES_BUSY : `CADC_EDGES_PLAIN;

  // Conversion timing
  cadc_conv_timer #(
    .CNT_W(CNT_W),
    .MIN_CYCLES(MIN_CYCLES),
    .MAX_CYCLES(MAX_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .reset(reset),
    .start(start_conv),
    .running(conv_running),
    .done(conv_done)
  );

  // Next state and readout control
  always @* begin
    state_next = state_reg;
    cs_mode_next = cs_mode_reg;
    busy_next = busy_reg;
    shift_next = shift_reg;
    edge_cnt_next = edge_cnt_reg;
    oe_n_next = oe_n_reg;
    start_conv = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (trig_rise) begin
          // Mode is taken from the level just before the edge
          cs_mode_next = prev_reg[`CADC_PIN_MODE];
          oe_n_next = 1'b1;
          start_conv = 1'b1;
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        // Trigger and mode levels do not matter until the end
        if (conv_done) begin
          edge_cnt_next = 5'h00;
          if (!cs_mode_reg) begin
            busy_next = 1'b0;
            state_next = ST_IDLE;
          end else if (!trig_s || !mode_s) begin
            busy_next = 1'b1;
            shift_next = {`CADC_BUSY_LEVEL, quantizer_code};
            oe_n_next = 1'b0;
            state_next = ST_SHIFT;
          end else begin
            busy_next = 1'b0;
            shift_next = {quantizer_code, 1'b0};
            state_next = ST_READY;
          end
        end
      end
      ST_READY: begin
        if (trig_rise) begin
          cs_mode_next = prev_reg[`CADC_PIN_MODE];
          start_conv = 1'b1;
          state_next = ST_CONV;
        end else if (sel_fall) begin
          oe_n_next = 1'b0;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (trig_rise) begin
          oe_n_next = 1'b1;
          cs_mode_next = prev_reg[`CADC_PIN_MODE];
          start_conv = 1'b1;
          state_next = ST_CONV;
        end else if (mode_rise) begin
          oe_n_next = 1'b1;
          state_next = ST_IDLE;
        end else if (sclk_fall) begin
          // Bit changes only on a falling edge and holds otherwise
          shift_next = {shift_reg[FRAME_W-2:0], 1'b0};
          edge_cnt_next = edge_cnt_reg + 5'h01;
          if (edge_cnt_reg + 5'h01 == edge_limit) begin
            oe_n_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        oe_n_next = 1'b1;
      end
    endcase
  end

  // Control state registers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cs_mode_reg <= 1'b1;
      busy_reg <= 1'b0;
      edge_cnt_reg <= 5'h00;
      oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cs_mode_reg <= cs_mode_next;
      busy_reg <= busy_next;
      edge_cnt_reg <= edge_cnt_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // Data path registers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shift_reg <= {FRAME_W{1'b0}};
      out_reg <= 1'b0;
      result_reg <= {DATA_W{1'b0}};
      sample_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      out_reg <= shift_next[FRAME_W-1];
      sample_reg <= start_conv;
      if (conv_done) begin
        result_reg <= quantizer_code;
      end
    end
  end

  // Pin and status outputs
  assign serial_out = out_reg;
  assign serial_out_oe_n = oe_n_reg;
  assign sample_hold = sample_reg;
  assign chip_select_mode = cs_mode_reg;
  assign daisy_chain_mode = !cs_mode_reg;
  assign busy_bit_armed = busy_reg;
  assign converting = conv_running;
  assign acquisition_power_down = !conv_running;
  assign last_result = result_reg;

endmodule

// ===== test/cadc_readout_monitor.sv
// Assertions on the readout block ports
`timescale 1ns/10ps
module cadc_readout_chk #(
  parameter int MIN_CYCLES = 30,
  parameter int MAX_CYCLES = 70
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Pins
  input wire conversion_trigger,
  input wire mode_select,
  input wire serial_clk,
  input wire serial_out,
  input wire serial_out_oe_n,
  // Status
  input wire [15:0] quantizer_code,
  input wire sample_hold,
  input wire daisy_chain_mode,
  input wire busy_bit_armed,
  input wire converting,
  input wire [15:0] last_result
);
  int cnt;
  always @(posedge core_clk or posedge reset) begin
    if (reset)
      cnt <= 0;
    else
      cnt <= converting ? cnt + 1 : 0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_busy_out;
    !serial_out_oe_n && !serial_out;
  endsequence
  a_conv_bounds: assert property (
    $fell(converting) |-> cnt >= MIN_CYCLES && cnt <= MAX_CYCLES) else $error("bad length");
  a_hold_float: assert property (
    sample_hold |-> serial_out_oe_n ##1 !sample_hold) else $error("bad sample");
  a_conv_quiet: assert property (
    converting |-> serial_out_oe_n) else $error("driven in conversion");
  a_daisy_quiet: assert property (
    daisy_chain_mode && $past(daisy_chain_mode) |-> serial_out_oe_n) else $error("daisy drives");
  a_busy_bit: assert property (
    $rose(busy_bit_armed) |-> ##[0:2] s_busy_out) else $error("no busy bit");
  a_result_latch: assert property (
    $fell(converting) |-> ##[0:1] last_result == quantizer_code) else $error("bad result");
  a_bit_stable: assert property (
    $changed(serial_out) && !$past(serial_out_oe_n) |-> !serial_clk) else $error("bit moved");
  a_trig_float: assert property (
    $rose(conversion_trigger) |-> ##[2:5] serial_out_oe_n) else $error("no float");
  a_mode_float: assert property (
    $rose(mode_select) && conversion_trigger |-> ##[2:5] serial_out_oe_n) else $error("no float");
endmodule
bind cadc_readout cadc_readout_chk #(.MIN_CYCLES(MIN_CYCLES), .MAX_CYCLES(MAX_CYCLES)) u_chk (
  .core_clk(core_clk), .reset(reset), .conversion_trigger(conversion_trigger),
  .mode_select(mode_select), .serial_clk(serial_clk), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n), .quantizer_code(quantizer_code),
  .sample_hold(sample_hold), .daisy_chain_mode(daisy_chain_mode),
  .busy_bit_armed(busy_bit_armed), .converting(converting), .last_result(last_result));

// ===== test/cadc_host_model.sv
// Host model driving the converter pins
`timescale 1ns/10ps
module cadc_host_model (
  // Clock
  input wire core_clk,
  // Pins
  output logic conversion_trigger,
  output logic mode_select,
  output logic serial_clk,
  input wire serial_out,
  input wire serial_out_oe_n
);
  initial begin
    conversion_trigger = 1'h0;
    mode_select = 1'h1;
    serial_clk = 1'h0;
  end
  task automatic wc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic frame(input logic four, input logic busy, input int nfall,
                       output logic [16:0] word, output logic oen);
    int i;
    mode_select = 1'h1;
    conversion_trigger = 1'h0;
    wc(20);
    conversion_trigger = 1'h1;
    wc(2);
    if (busy && four) mode_select = 1'h0;
    if (busy && !four) conversion_trigger = 1'h0;
    wc(20);
    if (!busy && four) mode_select = 1'h0;
    if (!busy && !four) conversion_trigger = 1'h0;
    wc(6);
    word = '0;
    for (i = 0; i < nfall; i++) begin
      word = {word[15:0], serial_out_oe_n ? 1'bx : serial_out};
      serial_clk = 1'h1;
      wc(8);
      serial_clk = 1'h0;
      wc(8);
    end
    oen = serial_out_oe_n;
  endtask
  task automatic daisy();
    mode_select = 1'h0;
    conversion_trigger = 1'h0;
    wc(6);
    conversion_trigger = 1'h1;
    wc(20);
  endtask
  task automatic rise_trig();
    conversion_trigger = 1'h1;
    wc(5);
  endtask
  task automatic rise_mode();
    mode_select = 1'h1;
    wc(5);
  endtask
endmodule

// ===== test/cadc_readout_test.sv
// Self-checking bench for the converter readout block
`timescale 1ns/10ps
module cadc_readout_test;
  typedef struct packed {logic four; logic busy; logic [15:0] code;} cadc_row_t;
  logic core_clk, reset, conversion_trigger, mode_select, serial_clk, oen;
  logic serial_out, serial_out_oe_n, converting, daisy_chain_mode;
  logic chip_select_mode, acquisition_power_down;
  logic [15:0] quantizer_code, last_result;
  logic [16:0] word;
  int err_count, samples_checked, cycles;
  cadc_row_t rows [4] = '{'{1'h0, 1'h0, 16'h0000}, '{1'h0, 1'h1, 16'hFFFF},
                          '{1'h1, 1'h0, 16'hA5C3}, '{1'h1, 1'h1, 16'h8001}};
  cadc_readout #(.MIN_CYCLES(10'h4), .MAX_CYCLES(10'h8)) dut (
    .core_clk(core_clk), .reset(reset), .conversion_trigger(conversion_trigger),
    .mode_select(mode_select), .serial_clk(serial_clk), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .quantizer_code(quantizer_code), .sample_hold(),
    .chip_select_mode(chip_select_mode), .daisy_chain_mode(daisy_chain_mode),
    .busy_bit_armed(), .converting(converting),
    .acquisition_power_down(acquisition_power_down), .last_result(last_result));
  cadc_host_model host (
    .core_clk(core_clk), .conversion_trigger(conversion_trigger), .mode_select(mode_select),
    .serial_clk(serial_clk), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic [16:0] e, input logic [16:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      err_count++;
    end
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    reset = 1'h1;
    quantizer_code = 16'h0000;
    repeat (20) @(negedge core_clk);
    chk("oe_n in reset", 17'h1, {16'h0, serial_out_oe_n});
    chk("result in reset", 17'h0, {1'h0, last_result});
    reset = 1'h0;
    repeat (4) @(negedge core_clk);
    foreach (rows[i]) begin
      quantizer_code = rows[i].code;
      host.frame(rows[i].four, rows[i].busy, rows[i].busy ? 17 : 16, word, oen);
      chk("frame bits", {1'h0, rows[i].code}, word);
      chk("float at end", 17'h1, {16'h0, oen});
      chk("latched", {1'h0, rows[i].code}, {1'h0, last_result});
      chk("power down", 17'h1, {16'h0, acquisition_power_down});
    end
    quantizer_code = 16'h1234;
    host.frame(1'h0, 1'h0, 4, word, oen);
    chk("partial bits", 17'h1, word);
    host.rise_trig();
    chk("float on trigger", 17'h1, {16'h0, serial_out_oe_n});
    chk("converting", 17'h1, {16'h0, converting});
    chk("awake", 17'h0, {16'h0, acquisition_power_down});
    host.daisy();
    chk("daisy mode", 17'h1, {16'h0, daisy_chain_mode});
    chk("chip-select off", 17'h0, {16'h0, chip_select_mode});
    chk("daisy floats", 17'h1, {16'h0, serial_out_oe_n});
    host.frame(1'h1, 1'h0, 16, word, oen);
    chk("chip-select again", 17'h1234, word);
    chk("chip-select on", 17'h1, {16'h0, chip_select_mode});
    host.frame(1'h1, 1'h1, 5, word, oen);
    chk("busy partial bits", 17'h1, word);
    host.rise_mode();
    chk("float on select", 17'h1, {16'h0, serial_out_oe_n});
    finish_test();
  end
endmodule
